// [core/slpr_pkg.sv]
// Summary of operation
// - link parameter fields other than the link-0-only bits are paged; accesses reach the copy of the link selected by the page
// - lane identity holds a five-bit read/write lane number, reset zero
// - bit 6 of lane identity: read/write lmfc adjust direction, reset zero
// - bit 5 of lane identity: read/write phase adjust request, reset zero
// - adjust direction, phase request and control bits exist for link 0 only
// - lane-count bit 7 enables descrambling, reset one
// - lane-count low five bits: lanes minus one, read/write, reset seven
// - eight-bit read/write octets per frame minus one, reset zero
// - five-bit frames per multiframe minus one, reset all ones meaning 32
// - eight-bit read/write converters per link minus one, reset one
// - resolution bits 7:6 read-only control bits per sample, reset zero
// - resolution low five bits: resolution minus one, read/write, reset fifteen
// - sample-width bits 7:5 select subclass, 000 subclass 0, 001 subclass 1
// - sample-width low five bits: bits per sample minus one, reset fifteen
// - samples bits 7:5 protocol version, 000 A, 001 B, reset 000
// - samples low five bits: samples per frame minus one, reset one
package slpr_pkg;
  localparam int NUM_LINKS = 2;
  localparam int ADDR_W = 14;
  localparam int IDX_W = 12;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] LINK_PAGE_IDX = 12'h300;
  localparam logic [IDX_W-1:0] LANE_IDENT_IDX = 12'h452;
  localparam logic [IDX_W-1:0] LANE_COUNT_IDX = 12'h453;
  localparam logic [IDX_W-1:0] OCTETS_IDX = 12'h454;
  localparam logic [IDX_W-1:0] MULTIFRAME_IDX = 12'h455;
  localparam logic [IDX_W-1:0] CONVERTERS_IDX = 12'h456;
  localparam logic [IDX_W-1:0] RESOLUTION_IDX = 12'h457;
  localparam logic [IDX_W-1:0] SAMPLE_WIDTH_IDX = 12'h458;
  localparam logic [IDX_W-1:0] SAMPLES_IDX = 12'h459;
  localparam logic [IDX_W-1:0] SOFT_RESET_IDX = 12'h475;

  // field positions
  localparam int PAGE_BIT = 0;
  localparam int SOFT_RESET_BIT = 3;
  localparam int ADJ_DIR_BIT = 6;
  localparam int PHASE_REQ_BIT = 5;
  localparam int DESCRAMBLE_BIT = 7;
  localparam int CTRL_BITS_LSB = 6;
  localparam int SUBCLASS_LSB = 5;
  localparam int VERSION_LSB = 5;

  // reset values
  localparam logic [4:0] LANE_IDENT_RST = 5'h00;
  localparam logic ADJ_DIR_RST = 1'b0;
  localparam logic PHASE_REQ_RST = 1'b0;
  localparam logic DESCRAMBLE_RST = 1'b1;
  localparam logic [4:0] LANES_RST = 5'h07;
  localparam logic [7:0] OCTETS_RST = 8'h00;
  localparam logic [4:0] FRAMES_RST = 5'h1f;
  localparam logic [7:0] CONVERTERS_RST = 8'h01;
  localparam logic [1:0] CTRL_BITS_RST = 2'h0;
  localparam logic [4:0] RESOLUTION_RST = 5'h0f;
  localparam logic [2:0] SUBCLASS_RST = 3'h0;
  localparam logic [4:0] SAMPLE_WIDTH_RST = 5'h0f;
  localparam logic [2:0] VERSION_RST = 3'h0;
  localparam logic [4:0] SAMPLES_RST = 5'h01;
  localparam logic SOFT_RESET_RST = 1'b0;
  localparam logic PAGE_RST = 1'b0;

  // subclass and protocol encodings
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [2:0] VERSION_A = 3'h0;
  localparam logic [2:0] VERSION_B = 3'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/slpr_top.sv]
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module slpr_top
  import slpr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [slpr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [slpr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] control_bits_status,
  output logic link_page,
  output logic link_deframer_soft_reset,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] lane_ident,
  output logic lmfc_adjust_direction,
  output logic phase_adjust_request,
  output logic [slpr_pkg::NUM_LINKS-1:0] whitening_removal_enable,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] lanes_minus_one,
  output logic [slpr_pkg::NUM_LINKS-1:0][7:0] octets_minus_one,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] frames_minus_one,
  output logic [slpr_pkg::NUM_LINKS-1:0][7:0] converters_minus_one,
  output logic [1:0] control_bits_per_sample,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] resolution_minus_one,
  output logic [slpr_pkg::NUM_LINKS-1:0][2:0] subclass_version,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] sample_width_minus_one,
  output logic [slpr_pkg::NUM_LINKS-1:0][2:0] protocol_version,
  output logic [slpr_pkg::NUM_LINKS-1:0][4:0] samples_minus_one
);
  import slpr_pkg::*;

  logic aw_held_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic w_held_reg;
  logic [7:0] w_byte_reg;
  logic w_lane0_reg;
  logic do_write;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [IDX_W-1:0] ar_idx;
  logic wr_en;
  logic page_sel;
  logic wr_page;
  logic wr_soft_reset;
  logic wr_lane_ident;
  logic wr_lane_count;
  logic wr_octets;
  logic wr_multiframe;
  logic wr_converters;
  logic wr_resolution;
  logic wr_sample_width;
  logic wr_samples;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // a write completes once address and data are both held and no response is pending
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  // data sits in byte lane 0; other lanes carry nothing
  assign wr_en = do_write && w_lane0_reg;
  assign page_sel = link_page;

  // one strobe per register so each storage block below stays small
  assign wr_page = wr_en && aw_idx_reg == LINK_PAGE_IDX;
  assign wr_soft_reset = wr_en && aw_idx_reg == SOFT_RESET_IDX;
  assign wr_lane_ident = wr_en && aw_idx_reg == LANE_IDENT_IDX;
  assign wr_lane_count = wr_en && aw_idx_reg == LANE_COUNT_IDX;
  assign wr_octets = wr_en && aw_idx_reg == OCTETS_IDX;
  assign wr_multiframe = wr_en && aw_idx_reg == MULTIFRAME_IDX;
  assign wr_converters = wr_en && aw_idx_reg == CONVERTERS_IDX;
  assign wr_resolution = wr_en && aw_idx_reg == RESOLUTION_IDX;
  assign wr_sample_width = wr_en && aw_idx_reg == SAMPLE_WIDTH_IDX;
  assign wr_samples = wr_en && aw_idx_reg == SAMPLES_IDX;

  always_comb begin
    aw_held_next = aw_held_reg;
    if (aw_take) begin
      aw_held_next = 1'b1;
    end else if (do_write) begin
      aw_held_next = 1'b0;
    end
    w_held_next = w_held_reg;
    if (w_take) begin
      w_held_next = 1'b1;
    end else if (do_write) begin
      w_held_next = 1'b0;
    end
    bvalid_next = s_axi_bvalid;
    if (do_write) begin
      bvalid_next = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_comb begin
    case (aw_idx_reg)
      LINK_PAGE_IDX, SOFT_RESET_IDX, LANE_IDENT_IDX, LANE_COUNT_IDX, OCTETS_IDX,
      MULTIFRAME_IDX, CONVERTERS_IDX, RESOLUTION_IDX, SAMPLE_WIDTH_IDX, SAMPLES_IDX: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 12'h000;
    end else begin
      aw_held_reg <= aw_held_next;
      if (aw_take) begin
        aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
      end
    end
  end

  // only byte lane 0 carries register data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      w_held_reg <= w_held_next;
      if (w_take) begin
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // ready drops as soon as a beat is held, so a second beat never overwrites it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // page only moves on a completed write, never mid-access
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_page <= PAGE_RST;
    end else if (wr_page) begin
      link_page <= w_byte_reg[PAGE_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_deframer_soft_reset <= SOFT_RESET_RST;
    end else if (wr_soft_reset) begin
      link_deframer_soft_reset <= w_byte_reg[SOFT_RESET_BIT];
    end
  end

  // control bits come from the receiver side; software cannot write them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_bits_per_sample <= CTRL_BITS_RST;
    end else begin
      control_bits_per_sample <= control_bits_status;
    end
  end

  // link-0-only controls; writes on another page are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lmfc_adjust_direction <= ADJ_DIR_RST;
      phase_adjust_request <= PHASE_REQ_RST;
    end else if (wr_lane_ident && page_sel == 1'b0) begin
      lmfc_adjust_direction <= w_byte_reg[ADJ_DIR_BIT];
      phase_adjust_request <= w_byte_reg[PHASE_REQ_BIT];
    end
  end

  // paged link parameters, one block per register; reserved positions are never stored
  // lane number is not gated by soft reset; software keeps it stable while running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        lane_ident[i] <= LANE_IDENT_RST;
      end
    end else if (wr_lane_ident) begin
      lane_ident[page_sel] <= w_byte_reg[4:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        whitening_removal_enable[i] <= DESCRAMBLE_RST;
        lanes_minus_one[i] <= LANES_RST;
      end
    end else if (wr_lane_count) begin
      whitening_removal_enable[page_sel] <= w_byte_reg[DESCRAMBLE_BIT];
      lanes_minus_one[page_sel] <= w_byte_reg[4:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        octets_minus_one[i] <= OCTETS_RST;
      end
    end else if (wr_octets) begin
      octets_minus_one[page_sel] <= w_byte_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        frames_minus_one[i] <= FRAMES_RST;
      end
    end else if (wr_multiframe) begin
      frames_minus_one[page_sel] <= w_byte_reg[4:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        converters_minus_one[i] <= CONVERTERS_RST;
      end
    end else if (wr_converters) begin
      converters_minus_one[page_sel] <= w_byte_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        resolution_minus_one[i] <= RESOLUTION_RST;
      end
    end else if (wr_resolution) begin
      resolution_minus_one[page_sel] <= w_byte_reg[4:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        subclass_version[i] <= SUBCLASS_RST;
        sample_width_minus_one[i] <= SAMPLE_WIDTH_RST;
      end
    end else if (wr_sample_width) begin
      subclass_version[page_sel] <= w_byte_reg[SUBCLASS_LSB+:3];
      sample_width_minus_one[page_sel] <= w_byte_reg[4:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        protocol_version[i] <= VERSION_RST;
        samples_minus_one[i] <= SAMPLES_RST;
      end
    end else if (wr_samples) begin
      protocol_version[page_sel] <= w_byte_reg[VERSION_LSB+:3];
      samples_minus_one[page_sel] <= w_byte_reg[4:0];
    end
  end

  // reserved positions are built from zero constants
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      LINK_PAGE_IDX: begin
        rd_byte = {7'h00, link_page};
      end
      SOFT_RESET_IDX: begin
        rd_byte = {4'h0, link_deframer_soft_reset, 3'h0};
      end
      LANE_IDENT_IDX: begin
        if (page_sel == 1'b0) begin
          rd_byte = {1'b0, lmfc_adjust_direction, phase_adjust_request, lane_ident[0]};
        end else begin
          rd_byte = {3'h0, lane_ident[page_sel]};
        end
      end
      LANE_COUNT_IDX: begin
        rd_byte = {whitening_removal_enable[page_sel], 2'h0, lanes_minus_one[page_sel]};
      end
      OCTETS_IDX: begin
        rd_byte = octets_minus_one[page_sel];
      end
      MULTIFRAME_IDX: begin
        rd_byte = {3'h0, frames_minus_one[page_sel]};
      end
      CONVERTERS_IDX: begin
        rd_byte = converters_minus_one[page_sel];
      end
      RESOLUTION_IDX: begin
        if (page_sel == 1'b0) begin
          rd_byte = {control_bits_per_sample, 1'b0, resolution_minus_one[0]};
        end else begin
          rd_byte = {3'h0, resolution_minus_one[page_sel]};
        end
      end
      SAMPLE_WIDTH_IDX: begin
        rd_byte = {subclass_version[page_sel], sample_width_minus_one[page_sel]};
      end
      SAMPLES_IDX: begin
        rd_byte = {protocol_version[page_sel], samples_minus_one[page_sel]};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read at a time; arready falls while a response waits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // data is captured at the take edge and held until the handshake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end
endmodule
`default_nettype wire

// [core/README_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [sim/slpr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module slpr_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] control_bits_status,
  input wire logic link_page,
  input wire logic [slpr_pkg::NUM_LINKS-1:0][4:0] lane_ident,
  input wire logic lmfc_adjust_direction,
  input wire logic phase_adjust_request,
  input wire logic [slpr_pkg::NUM_LINKS-1:0] whitening_removal_enable,
  input wire logic [1:0] control_bits_per_sample,
  input wire logic [slpr_pkg::NUM_LINKS-1:0][2:0] subclass_version
);
  import slpr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_B_AFTER_TAKE: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_R_AFTER_TAKE: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_RDATA_BYTE: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  AST_LANE_ON_WRITE: assert property (
    !$rose(s_axi_bvalid) |-> $stable(lane_ident)) else $error("lane number moved");
  AST_DESCR_ON_WRITE: assert property (
    !$rose(s_axi_bvalid) |-> $stable(whitening_removal_enable))
    else $error("descramble flag moved");
  AST_ADJ_LINK0: assert property (
    $changed(lmfc_adjust_direction) |-> $rose(s_axi_bvalid) && !link_page)
    else $error("adjust direction moved");
  AST_PHASE_LINK0: assert property (
    $changed(phase_adjust_request) |-> $rose(s_axi_bvalid) && !link_page)
    else $error("phase request moved");
  AST_CTRL_SAMPLED: assert property (
    !$past(rst) |-> control_bits_per_sample == $past(control_bits_status))
    else $error("control bits not sampled");
  AST_SUBCLASS_ON_WRITE: assert property (
    !$rose(s_axi_bvalid) |-> $stable(subclass_version)) else $error("subclass moved");
endmodule
bind slpr_top slpr_monitor i_slpr_monitor (.*);
`default_nettype wire

// [sim/test_serial_link_param_registers.sv]
`timescale 1ns/1ps
`default_nettype none
module test_serial_link_param_registers;
  import slpr_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] cbs = 0;
  logic awready, wready, bvalid, arready, rvalid, adj;
  logic [1:0] bresp, rresp, cbps;
  logic [31:0] rdata;
  logic [NUM_LINKS-1:0][4:0] lid;
  logic [NUM_LINKS-1:0][2:0] subv, ver;
  logic [NUM_LINKS-1:0] descr;
  logic pg, sr, phr;
  logic [NUM_LINKS-1:0][4:0] lanes, frm, res, npw, smp;
  logic [NUM_LINKS-1:0][7:0] oct, conv;
  logic [3:0] strb = 4'h1;
  int n_fail = 0;
  int n_checks = 0;
  logic [7:0] rv [8] = '{8'h00, 8'h87, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h0f, 8'h01};
  logic [7:0] fv [8] = '{8'h7f, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'hff};

  slpr_top i_slpr_top (
    .clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .control_bits_status(cbs), .link_page(pg), .link_deframer_soft_reset(sr), .lane_ident(lid),
    .lmfc_adjust_direction(adj), .phase_adjust_request(phr), .whitening_removal_enable(descr),
    .lanes_minus_one(lanes), .octets_minus_one(oct), .frames_minus_one(frm),
    .converters_minus_one(conv), .control_bits_per_sample(cbps), .resolution_minus_one(res),
    .subclass_version(subv), .sample_width_minus_one(npw), .protocol_version(ver),
    .samples_minus_one(smp)
  );

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [IDX_W-1:0] ix, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, a1, w1;
    ta = 0;
    tw = 0;
    @(posedge clock);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ta && tw)) begin
      @(negedge clock);
      a1 = awvalid && awready;
      w1 = wvalid && wready;
      @(posedge clock);
      if (a1) awvalid <= 0;
      if (w1) wvalid <= 0;
      ta |= a1;
      tw |= w1;
    end
    do @(negedge clock); while (!bvalid);
    chk($sformatf("bresp %h", ix), 32'(er), 32'(bresp));
    @(posedge clock);
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [IDX_W-1:0] ix, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clock);
    araddr <= {ix, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 0;
    do @(negedge clock); while (!rvalid);
    chk($sformatf("rdata %h", ix), {24'h00_0000, ed}, rdata);
    chk($sformatf("rresp %h", ix), 32'(er), 32'(rresp));
    @(posedge clock);
    rready <= 0;
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hung handshake ends here; the tests need about two hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    final_report;
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 8; i++) begin
      axi_rd(LANE_IDENT_IDX + 12'(i), rv[i], RESP_OKAY);
    end
    axi_wr(SOFT_RESET_IDX, 8'h08, RESP_OKAY);
    axi_rd(SOFT_RESET_IDX, 8'h08, RESP_OKAY);
    chk("soft_reset_on", 32'h1, 32'(sr));
    for (int i = 0; i < 8; i++) begin
      axi_wr(LANE_IDENT_IDX + 12'(i), 8'hff, RESP_OKAY);
      axi_rd(LANE_IDENT_IDX + 12'(i), fv[i], RESP_OKAY);
    end
    chk("lane_ident0", 32'h1f, 32'(lid[0]));
    chk("adjust_dir", 32'h1, 32'(adj));
    chk("descramble", 32'h1, 32'(descr[0]));
    chk("page0", 32'h0, 32'(pg));
    chk("phase_req", 32'h1, 32'(phr));
    chk("lanes0", 32'h1f, 32'(lanes[0]));
    chk("octets0", 32'hff, 32'(oct[0]));
    chk("frames0", 32'h1f, 32'(frm[0]));
    chk("converters0", 32'hff, 32'(conv[0]));
    chk("resolution0", 32'h1f, 32'(res[0]));
    chk("sample_width0", 32'h1f, 32'(npw[0]));
    chk("samples0", 32'h1f, 32'(smp[0]));
    axi_wr(LINK_PAGE_IDX, 8'h01, RESP_OKAY);
    axi_rd(LINK_PAGE_IDX, 8'h01, RESP_OKAY);
    chk("page1", 32'h1, 32'(pg));
    for (int i = 0; i < 8; i++) begin
      axi_rd(LANE_IDENT_IDX + 12'(i), rv[i], RESP_OKAY);
    end
    axi_wr(LANE_IDENT_IDX, 8'h9f, RESP_OKAY);
    axi_rd(LANE_IDENT_IDX, 8'h1f, RESP_OKAY);
    chk("lane_ident1", 32'h1f, 32'(lid[1]));
    chk("adjust_dir_kept", 32'h1, 32'(adj));
    chk("phase_req_kept", 32'h1, 32'(phr));
    chk("lanes1", 32'h07, 32'(lanes[1]));
    chk("octets1", 32'h00, 32'(oct[1]));
    axi_wr(SOFT_RESET_IDX, 8'h00, RESP_OKAY);
    chk("soft_reset_off", 32'h0, 32'(sr));
    axi_wr(LINK_PAGE_IDX, 8'h00, RESP_OKAY);
    cbs <= 2'h2;
    axi_rd(RESOLUTION_IDX, 8'h9f, RESP_OKAY);
    chk("ctrl_bits", 32'h2, 32'(cbps));
    for (int e = 0; e < 2; e++) begin
      axi_wr(SAMPLE_WIDTH_IDX, {3'(e), 5'h0f}, RESP_OKAY);
      chk("subclass", 32'(e ? SUBCLASS_1 : SUBCLASS_0), 32'(subv[0]));
      axi_wr(SAMPLES_IDX, {3'(e), 5'h01}, RESP_OKAY);
      chk("version", 32'(e ? VERSION_B : VERSION_A), 32'(ver[0]));
    end
    strb <= 4'h0;
    axi_wr(OCTETS_IDX, 8'h00, RESP_OKAY);
    axi_rd(OCTETS_IDX, 8'hff, RESP_OKAY);
    strb <= 4'h1;
    axi_wr(12'h45a, 8'hff, RESP_SLVERR);
    axi_rd(12'h45a, 8'h00, RESP_SLVERR);
    final_report;
  end
endmodule
`default_nettype wire
